// File: inc/clock_prescalers_pkg.sv
// constants, types and register map for the prescalers and wake wait block
// assumes a single system clock and an 8-bit register port
package clock_prescalers_pkg;
  localparam int SYS_PRESCALER_W = 13;
  localparam int SUB_PRESCALER_W = 5;
  localparam int WAIT_CNT_W      = 17;
  localparam int CLK_PERIOD_NS   = 40;

  // register offsets on the plain port
  localparam logic [3:0] OSC_CTRL_ADDR   = 4'h0;
  localparam logic [3:0] SYS_CTRL1_ADDR  = 4'h1;
  localparam logic [3:0] TIMER_MODE_ADDR = 4'h2;

  // field positions
  localparam int SUBCLOCK_STOP_BIT = 7;
  localparam int IRQAEC_FLAG_BIT   = 2;
  localparam int OSC_FLAG_BIT      = 1;
  localparam int WAIT_SEL_LSB      = 4;
  localparam int TIMER_BIT3        = 3;
  localparam int TIMER_BIT2        = 2;

  // values after reset
  localparam logic [7:0] OSC_CTRL_RESET   = 8'h00;
  localparam logic [2:0] WAIT_SEL_RESET   = 3'h0;
  localparam logic [7:0] TIMER_MODE_RESET = 8'h00;

  // subclock divided by four, medium-speed divider terminal counts
  localparam logic [1:0] SUB_DIV_LAST  = 2'h3;
  localparam logic [6:0] MED_DIV16_LAST  = 7'h0f;
  localparam logic [6:0] MED_DIV32_LAST  = 7'h1f;
  localparam logic [6:0] MED_DIV64_LAST  = 7'h3f;
  localparam logic [6:0] MED_DIV128_LAST = 7'h7f;

  // wait lengths in states for selects 0 to 4; longer ones are top parameters
  localparam int WAIT_STATES_0 = 8;
  localparam int WAIT_STATES_1 = 16;
  localparam int WAIT_STATES_2 = 1024;
  localparam int WAIT_STATES_3 = 2048;
  localparam int WAIT_STATES_4 = 4096;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic       low_power;
    logic       subactive;
    logic       medium_speed;
    logic [1:0] medium_div;
  } mode_t;

  typedef enum logic [1:0] {RUNNING, CLOCK_HALTED, OSC_SETTLE, STATE_WAIT} wake_state_t;
endpackage : clock_prescalers_pkg

// File: core/clock_prescalers_and_osc_wait.sv
// system and subclock prescalers, subclock stop control and wake wait sequencer
// assumes mode, wake and tick inputs synchronous to clk_sys_in
`timescale 1ns/1ps

// Notes on behaviour
// - writing 1 to subclock stop halts the subclock oscillator; 0 keeps it running
// - system prescaler is a 13-bit up-counter advancing once per system clock
// - reset clears the system prescaler; counting starts when reset ends
// - in low-power modes the system prescaler halts and is cleared
// - the system prescaler has no software-visible register
// - all peripheral consumers share the system prescaler taps, each picking its own
// - in medium-speed mode the prescaler input is oscillator divided by 16 to 128
// - subclock prescaler is a 5-bit up-counter on the subclock divided by four
// - reset clears the subclock prescaler; counting starts when reset ends
// - subclock prescaler keeps counting in low-power modes while subclock runs
// - writing ones to timer mode bits 3 and 2 clears the subclock prescaler
// - subclock prescaler taps serve as the interval timer clock source
// - on wake the system oscillator restarts when the interrupt is accepted
// - wait length is selected by bits 6 to 4 of system control register 1
// - after a clock halt cpu and peripherals are held for 8 to 131072 states
// - operation resumes only after stabilization plus selected wait both elapse
// - with debugger attached use internal oscillator, system oscillator for flash work
// - subclock stop is bit 7 of the oscillator control register
// - setting subclock stop in subactive mode stops the whole device
module clock_prescalers_and_osc_wait #(
  parameter int WAIT_STATES_5 = 8192,
  parameter int WAIT_STATES_6 = 32768,
  parameter int WAIT_STATES_7 = 131072
) (
  // clock and reset
  input  wire logic                                        clk_sys_in,
  input  wire logic                                        rst_n_in,
  // register port
  input  wire clock_prescalers_pkg::reg_req_t              reg_req_in,
  output logic [7:0]                                       reg_rdata_out,
  // operating mode and wake
  input  wire clock_prescalers_pkg::mode_t                 mode_in,
  input  wire logic                                        wake_accept_in,
  input  wire logic                                        osc_stable_in,
  // subclock tick, strap and debugger
  input  wire logic                                        sub_tick_in,
  input  wire logic                                        irqaec_strap_in,
  input  wire logic                                        debugger_in,
  input  wire logic                                        flash_prog_in,
  // clock control
  output logic                                             subclock_osc_enable_out,
  output logic                                             system_osc_enable_out,
  output logic                                             internal_osc_out,
  output logic                                             cpu_hold_out,
  output logic                                             device_stop_out,
  // prescaler taps
  output logic [clock_prescalers_pkg::SYS_PRESCALER_W-1:0] system_prescaler_out,
  output logic [clock_prescalers_pkg::SUB_PRESCALER_W-1:0] subclock_prescaler_out
);
  import clock_prescalers_pkg::*;

  logic                       subclock_stop;
  logic [2:0]                 osc_ctrl_spare;
  logic                       irqaec_flag;
  logic                       strap_taken;
  logic [2:0]                 wait_select;
  logic [7:0]                 timer_mode;
  logic [6:0]                 med_div;
  logic [1:0]                 sub_div;
  logic                       next_subclock_stop;
  logic [2:0]                 next_osc_ctrl_spare;
  logic                       next_irqaec_flag;
  logic                       next_strap_taken;
  logic [2:0]                 next_wait_select;
  logic [7:0]                 next_timer_mode;
  logic [6:0]                 next_med_div;
  logic [1:0]                 next_sub_div;
  logic [7:0]                 next_rdata;
  logic                       next_device_stop;
  logic                       next_internal_osc;
  logic [SYS_PRESCALER_W-1:0] next_sys_presc;
  logic [SUB_PRESCALER_W-1:0] next_sub_presc;
  logic                       osc_wr;
  logic                       timer_wr;
  logic                       sub_clear;
  logic [6:0]                 med_last;
  logic [7:0]                 osc_ctrl_view;

  assign osc_wr    = reg_req_in.wr && (reg_req_in.addr == OSC_CTRL_ADDR);
  assign timer_wr  = reg_req_in.wr && (reg_req_in.addr == TIMER_MODE_ADDR);
  assign sub_clear = timer_wr && reg_req_in.wdata[TIMER_BIT3] && reg_req_in.wdata[TIMER_BIT2];
  assign osc_ctrl_view = {subclock_stop, 1'b0, osc_ctrl_spare, irqaec_flag, internal_osc_out, 1'b0};

  always_comb begin
    next_subclock_stop  = subclock_stop;
    next_osc_ctrl_spare = osc_ctrl_spare;
    next_wait_select    = wait_select;
    next_timer_mode     = timer_mode;
    next_device_stop    = device_stop_out;
    next_strap_taken    = 1'b1;
    next_irqaec_flag    = strap_taken ? irqaec_flag : irqaec_strap_in;
    if (osc_wr) begin
      next_subclock_stop  = reg_req_in.wdata[SUBCLOCK_STOP_BIT];
      next_osc_ctrl_spare = reg_req_in.wdata[5:3];
      if (reg_req_in.wdata[SUBCLOCK_STOP_BIT] && mode_in.subactive) begin
        next_device_stop = 1'b1;
      end
    end
    if (reg_req_in.wr && (reg_req_in.addr == SYS_CTRL1_ADDR)) begin
      next_wait_select = reg_req_in.wdata[WAIT_SEL_LSB +: 3];
    end
    if (timer_wr) begin
      next_timer_mode = reg_req_in.wdata;
    end
    // the prescaler counters are not on the port
    next_rdata = 8'h00;
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        OSC_CTRL_ADDR:   next_rdata = osc_ctrl_view;
        SYS_CTRL1_ADDR:  next_rdata = {1'b0, wait_select, 4'h0};
        TIMER_MODE_ADDR: next_rdata = timer_mode;
        default:         next_rdata = 8'h00;
      endcase
    end
    // debugger run uses the internal oscillator, flash work the system one
    if (debugger_in) begin
      next_internal_osc = !flash_prog_in;
    end else begin
      next_internal_osc = next_irqaec_flag;
    end
    // system prescaler
    case (mode_in.medium_div)
      2'h0:    med_last = MED_DIV16_LAST;
      2'h1:    med_last = MED_DIV32_LAST;
      2'h2:    med_last = MED_DIV64_LAST;
      default: med_last = MED_DIV128_LAST;
    endcase
    next_med_div   = med_div + 7'h01;
    next_sys_presc = system_prescaler_out;
    if (mode_in.low_power) begin
      next_med_div   = 7'h00;
      next_sys_presc = '0;
    end else if (!mode_in.medium_speed) begin
      next_med_div   = 7'h00;
      next_sys_presc = system_prescaler_out + 13'h0001;
    end else if (med_div >= med_last) begin
      next_med_div   = 7'h00;
      next_sys_presc = system_prescaler_out + 13'h0001;
    end
    // subclock prescaler runs regardless of the power mode
    next_sub_div   = sub_div;
    next_sub_presc = subclock_prescaler_out;
    if (sub_tick_in && !subclock_stop) begin
      next_sub_div = sub_div + 2'h1;
      if (sub_div == SUB_DIV_LAST) begin
        next_sub_presc = subclock_prescaler_out + 5'h01;
      end
    end
    if (sub_clear) begin
      next_sub_div   = 2'h0;
      next_sub_presc = '0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      subclock_stop           <= OSC_CTRL_RESET[SUBCLOCK_STOP_BIT];
      osc_ctrl_spare          <= OSC_CTRL_RESET[5:3];
      irqaec_flag             <= 1'b0;
      strap_taken             <= 1'b0;
      internal_osc_out        <= 1'b0;
      wait_select             <= WAIT_SEL_RESET;
      timer_mode              <= TIMER_MODE_RESET;
      reg_rdata_out           <= 8'h00;
      device_stop_out         <= 1'b0;
      subclock_osc_enable_out <= 1'b1;
      med_div                 <= 7'h00;
      sub_div                 <= 2'h0;
      system_prescaler_out    <= '0;
      subclock_prescaler_out  <= '0;
    end else begin
      subclock_stop           <= next_subclock_stop;
      osc_ctrl_spare          <= next_osc_ctrl_spare;
      irqaec_flag             <= next_irqaec_flag;
      strap_taken             <= next_strap_taken;
      internal_osc_out        <= next_internal_osc;
      wait_select             <= next_wait_select;
      timer_mode              <= next_timer_mode;
      reg_rdata_out           <= next_rdata;
      device_stop_out         <= next_device_stop;
      subclock_osc_enable_out <= !next_subclock_stop;
      med_div                 <= next_med_div;
      sub_div                 <= next_sub_div;
      system_prescaler_out    <= next_sys_presc;
      subclock_prescaler_out  <= next_sub_presc;
    end
  end

  // wake sequencer: halt, oscillator settle, then counted wait
  wake_state_t           state;
  wake_state_t           next_state;
  logic [WAIT_CNT_W-1:0] wait_cnt;
  logic [WAIT_CNT_W-1:0] next_wait_cnt;
  logic [WAIT_CNT_W-1:0] wait_load;
  logic                  next_hold;
  logic                  next_sys_osc;

  always_comb begin
    case (wait_select)
      3'h0:    wait_load = WAIT_CNT_W'(WAIT_STATES_0 - 1);
      3'h1:    wait_load = WAIT_CNT_W'(WAIT_STATES_1 - 1);
      3'h2:    wait_load = WAIT_CNT_W'(WAIT_STATES_2 - 1);
      3'h3:    wait_load = WAIT_CNT_W'(WAIT_STATES_3 - 1);
      3'h4:    wait_load = WAIT_CNT_W'(WAIT_STATES_4 - 1);
      3'h5:    wait_load = WAIT_CNT_W'(WAIT_STATES_5 - 1);
      3'h6:    wait_load = WAIT_CNT_W'(WAIT_STATES_6 - 1);
      default: wait_load = WAIT_CNT_W'(WAIT_STATES_7 - 1);
    endcase
    next_state    = state;
    next_wait_cnt = wait_cnt;
    case (state)
      RUNNING: begin
        if (mode_in.low_power) begin
          next_state = CLOCK_HALTED;
        end
      end
      CLOCK_HALTED: begin
        if (wake_accept_in) begin
          next_state = OSC_SETTLE;
        end
      end
      OSC_SETTLE: begin
        if (osc_stable_in) begin
          next_state    = STATE_WAIT;
          next_wait_cnt = wait_load;
        end
      end
      STATE_WAIT: begin
        if (wait_cnt == '0) begin
          next_state = RUNNING;
        end else begin
          next_wait_cnt = wait_cnt - 17'h00001;
        end
      end
      default: next_state = RUNNING;
    endcase
    next_hold    = (next_state != RUNNING);
    next_sys_osc = (next_state != CLOCK_HALTED);
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state                 <= RUNNING;
      wait_cnt              <= '0;
      cpu_hold_out          <= 1'b0;
      system_osc_enable_out <= 1'b1;
    end else begin
      state                 <= next_state;
      wait_cnt              <= next_wait_cnt;
      cpu_hold_out          <= next_hold;
      system_osc_enable_out <= next_sys_osc;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  sequence settle_done_s;
    state == OSC_SETTLE && osc_stable_in;
  endsequence
  sequence held_min_s;
    cpu_hold_out [*8];
  endsequence

  stop_bit_a: assert property (osc_wr && reg_req_in.wdata[7] |=> !subclock_osc_enable_out)
    else $error("subclock not stopped after stop write");
  sys_count_a: assert property (!mode_in.low_power && !mode_in.medium_speed ##1 !mode_in.low_power
    |-> system_prescaler_out == $past(system_prescaler_out) + 13'h0001)
    else $error("system prescaler did not advance");
  reset_clear_a: assert property (disable iff (1'b0) !rst_n_in |=>
    system_prescaler_out == '0 && subclock_prescaler_out == '0)
    else $error("prescalers not cleared by reset");
  sys_halt_a: assert property (mode_in.low_power |=> system_prescaler_out == '0)
    else $error("system prescaler not cleared in low power");
  sub_clear_a: assert property (sub_clear |=> subclock_prescaler_out == '0)
    else $error("subclock prescaler not cleared");
  osc_restart_a: assert property (state == CLOCK_HALTED && wake_accept_in |=> system_osc_enable_out)
    else $error("oscillator not restarted on wake");
  min_wait_a: assert property (settle_done_s |=> held_min_s)
    else $error("hold shorter than eight states");
  no_early_a: assert property (state == OSC_SETTLE |-> ##1 cpu_hold_out)
    else $error("resumed before oscillator settled");
  // the hold must drop as soon as the counted wait reaches zero
  wait_release_a: assert property (state == STATE_WAIT && wait_cnt == '0 |=> !cpu_hold_out)
    else $error("hold not released after wait");
  dev_stop_a: assert property (osc_wr && reg_req_in.wdata[7] && mode_in.subactive |=> device_stop_out)
    else $error("device stop not raised");
  sub_wrap_a: assert property (subclock_prescaler_out == 5'h1f && !sub_clear ##1
    subclock_prescaler_out != 5'h1f |-> subclock_prescaler_out == 5'h00)
    else $error("subclock prescaler did not wrap to zero");
  sub_stop_a: assert property (subclock_stop && !sub_clear |=>
    subclock_prescaler_out == $past(subclock_prescaler_out))
    else $error("subclock prescaler moved while stopped");
  dbg_osc_a: assert property (debugger_in && flash_prog_in |=> !internal_osc_out)
    else $error("flash work not on system oscillator");
endmodule : clock_prescalers_and_osc_wait

// File: test/clock_prescalers_and_osc_wait_tb_top.sv
// self-checking bench for the prescalers and wake wait block
// assumes the block is driven directly by this bench, no partner model
`timescale 1ns/1ps
module clock_prescalers_and_osc_wait_tb_top;
  import clock_prescalers_pkg::*;
  localparam int W5 = 20;
  localparam int W6 = 24;
  localparam int W7 = 32;
  logic       clk, rst_n, wake, stable, tick, strap, dbg, flash;
  logic       sub_en, sys_en, int_osc, hold, dstop, rd_pend;
  reg_req_t   req;
  mode_t      mode;
  logic [7:0] rdata, v;
  logic [12:0] sys_cnt, a;
  logic [4:0] sub_cnt, b;
  logic [7:0] exp_q[$];
  int         errors, checks, n;

  clock_prescalers_and_osc_wait #(.WAIT_STATES_5(W5), .WAIT_STATES_6(W6), .WAIT_STATES_7(W7))
    i_clock_prescalers_and_osc_wait (.clk_sys_in(clk), .rst_n_in(rst_n), .reg_req_in(req),
    .reg_rdata_out(rdata), .mode_in(mode), .wake_accept_in(wake), .osc_stable_in(stable),
    .sub_tick_in(tick), .irqaec_strap_in(strap), .debugger_in(dbg), .flash_prog_in(flash),
    .subclock_osc_enable_out(sub_en), .system_osc_enable_out(sys_en), .internal_osc_out(int_osc),
    .cpu_hold_out(hold), .device_stop_out(dstop), .system_prescaler_out(sys_cnt),
    .subclock_prescaler_out(sub_cnt));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmp_val(input string name, input logic [16:0] e, input logic [16:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask : cmp_val

  task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value read data expected %h seen %h", e, g);
    end
  endtask : cmp_rd

  task automatic reg_write(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk);
    req.addr  <= ad;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk);
    req.wr    <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] ad, input logic [7:0] e);
    @(posedge clk);
    req.addr <= ad;
    req.rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    req.rd   <= 1'b0;
  endtask : reg_read

  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
  endtask : ticks

  task automatic wait_edges(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : wait_edges

  function automatic int wait_len(input int k);
    case (k)
      0: return WAIT_STATES_0;
      1: return WAIT_STATES_1;
      2: return WAIT_STATES_2;
      3: return WAIT_STATES_3;
      4: return WAIT_STATES_4;
      5: return W5;
      6: return W6;
      default: return W7;
    endcase
  endfunction : wait_len

  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) cmp_val("read queue", 17'h0, 17'h1);
      else cmp_rd(exp_q.pop_front(), rdata);
    end
    rd_pend <= req.rd;
  end

  initial begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'hc886));
    {rst_n, wake, stable, tick, strap, dbg, flash} = '0;
    req = '0;
    mode = '0;
    errors = 0;
    checks = 0;
    wait_edges(8);
    cmp_val("sys count", 17'h0, 17'(sys_cnt));
    cmp_val("sub count", 17'h0, 17'(sub_cnt));
    cmp_val("flags", 17'h3, 17'({sub_en, sys_en, int_osc, hold, dstop}) >> 3);
    rst_n <= 1'b1;
    wait_edges(2);
    cmp_val("count start", 17'h2, 17'(sys_cnt));
    a = sys_cnt;
    wait_edges(100);
    cmp_val("sys step", 17'(a + 13'd100), 17'(sys_cnt));
    wait_edges(8192);
    cmp_val("sys wrap", 17'(a + 13'd100), 17'(sys_cnt));
    reg_read(OSC_CTRL_ADDR, 8'h00);
    reg_read(4'h9, 8'h00);
    reg_write(4'h9, 8'hff);
    v = 8'($urandom_range(7));
    reg_write(OSC_CTRL_ADDR, {2'b01, v[2:0], 3'b111});
    reg_read(OSC_CTRL_ADDR, {2'b00, v[2:0], 3'b000});
    v = 8'($urandom) & 8'hf3;
    reg_write(TIMER_MODE_ADDR, v);
    reg_read(TIMER_MODE_ADDR, v);
    for (int d = 0; d < 4; d++) begin
      @(posedge clk);
      mode.medium_speed <= 1'b1;
      mode.medium_div   <= 2'(d);
      wait_edges(300);
      a = sys_cnt;
      wait_edges(4 * (16 << d));
      cmp_val("medium step", 17'(a + 13'd4), 17'(sys_cnt));
    end
    mode.medium_speed <= 1'b0;
    dbg <= 1'b1;
    wait_edges(3);
    cmp_val("internal osc", 17'h1, 17'(int_osc));
    flash <= 1'b1;
    wait_edges(3);
    cmp_val("flash osc", 17'h0, 17'(int_osc));
    {dbg, flash} <= 2'b00;
    b = sub_cnt;
    ticks(8);
    #1 cmp_val("sub step", 17'(b + 5'd2), 17'(sub_cnt));
    reg_write(TIMER_MODE_ADDR, 8'h0c);
    #1 cmp_val("sub clear", 17'h0, 17'(sub_cnt));
    ticks(132);
    #1 cmp_val("sub wrap", 17'h1, 17'(sub_cnt));
    reg_write(OSC_CTRL_ADDR, 8'h80);
    #1 cmp_val("sub enable", 17'h0, 17'(sub_en));
    ticks(8);
    #1 cmp_val("sub stopped", 17'h1, 17'(sub_cnt));
    cmp_val("no device stop", 17'h0, 17'(dstop));
    reg_read(OSC_CTRL_ADDR, 8'h80);
    reg_write(OSC_CTRL_ADDR, 8'h00);
    #1 cmp_val("sub enable", 17'h1, 17'(sub_en));
    for (int k = 0; k < 8; k++) begin
      reg_write(SYS_CTRL1_ADDR, {1'b0, 3'(k), 4'h0});
      reg_read(SYS_CTRL1_ADDR, {1'b0, 3'(k), 4'h0});
      mode.low_power <= 1'b1;
      wait_edges(3);
      cmp_val("halt", 17'h2, 17'({hold, sys_en}));
      cmp_val("sys cleared", 17'h0, 17'(sys_cnt));
      b = sub_cnt;
      ticks(4);
      #1 cmp_val("sub in sleep", 17'(b + 5'd1), 17'(sub_cnt));
      @(posedge clk);
      wake <= 1'b1;
      mode.low_power <= 1'b0;
      @(posedge clk);
      wake <= 1'b0;
      wait_edges(6);
      cmp_val("osc restart", 17'h3, 17'({hold, sys_en}));
      stable <= 1'b1;
      wait_edges(1);
      n = 0;
      while (hold === 1'b1 && n < 140000) begin
        n++;
        wait_edges(1);
      end
      cmp_val("wait states", 17'(wait_len(k)), 17'(n));
      stable <= 1'b0;
    end
    mode.subactive <= 1'b1;
    reg_write(OSC_CTRL_ADDR, 8'h80);
    reg_write(OSC_CTRL_ADDR, 8'h00);
    wait_edges(2);
    cmp_val("device stop", 17'h1, 17'(dstop));
    rst_n <= 1'b0;
    mode.subactive <= 1'b0;
    strap <= 1'($urandom);
    wait_edges(2);
    cmp_val("stop cleared", 17'h0, 17'(dstop));
    rst_n <= 1'b1;
    wait_edges(4);
    cmp_val("strap osc", 17'(strap), 17'(int_osc));
    reg_read(OSC_CTRL_ADDR, {5'h00, strap, strap, 1'b0});
    wait_edges(3);
    report_and_stop();
  end
endmodule : clock_prescalers_and_osc_wait_tb_top
